/* scs_checker.sv */
// Port checker of the clocked serial unit
`include "scs_defs.vh"
module scs_checker (
  // Clock and reset
  input wire clock,
  input wire reset,
  // Register port
  input wire [`SCS_ADDR_W-1:0] regAddr,
  input wire [7:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regReadData,
  // Pins and request
  input wire serialClockIn,
  input wire serialClockOut,
  input wire serialClockOe,
  input wire serialDataIn,
  input wire serialDataOut,
  input wire transferIrq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ctrlReg;
  logic enReg;
  logic [4:0] fallCnt;
  wire ctrlWr = regWrite && regAddr == `SCS_IDX_CTRL;
  wire csrWr = regWrite && regAddr == `SCS_IDX_CSR;
  wire csrRd = regRead && regAddr == `SCS_IDX_CSR;
  wire [4:0] len = ctrlReg[6] ? `SCS_LEN_16 : `SCS_LEN_8;
  wire inClk = !ctrlReg[`SCS_SRC_BIT];
  // Shadow of control, enable and clock falls since start
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrlReg <= 8'h00;
      enReg <= 1'b0;
      fallCnt <= 5'h00;
    end else begin
      if (ctrlWr)
        ctrlReg <= regWriteData;
      if (regWrite && regAddr == `SCS_IDX_IRQ)
        enReg <= regWriteData[`SCS_IRQ_EN];
      if (ctrlWr || (csrWr && regWriteData[0]))
        fallCnt <= 5'h00;
      else if ($fell(serialClockOut))
        fallCnt <= fallCnt + 5'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  AST_OE_INT:
    assert property (ctrlWr && !regWriteData[3] |-> ##[1:2] serialClockOe)
    else $error("clock pin not driven");
  AST_OE_EXT:
    assert property (ctrlWr && regWriteData[3] |-> ##[1:2] !serialClockOe)
    else $error("clock pin driven with outside source");
  AST_CSR_FIX:
    assert property (csrRd |=> regReadData[7] && regReadData[4:2] == 3'h0)
    else $error("fixed status bits wrong");
  AST_LVL_RD:
    assert property (csrRd ##1 $stable(serialDataOut)
      |-> regReadData[6] == serialDataOut)
    else $error("level bit differs from data pin");
  AST_CLK_CNT:
    assert property (inClk && !ctrlReg[7] |-> fallCnt <= len)
    else $error("clock pulses beyond the word");
  AST_CONT:
    assert property (ctrlReg == 8'h87 |-> ##[0:3] $fell(serialClockOut))
    else $error("continuous clock stopped");
  AST_DONE_CNT:
    assert property ($rose(transferIrq) && inClk |-> fallCnt == len)
    else $error("completion after wrong clock count");
  AST_IRQ_EN:
    assert property (transferIrq |-> $past(enReg))
    else $error("request while disabled");
  CV_INT: cover property ($rose(transferIrq) && inClk);
  CV_EXT: cover property ($rose(transferIrq) && !inClk);
  CV_WIDE: cover property ($rose(transferIrq) && ctrlReg[6]);
endmodule // scs_checker

bind scs_serial scs_checker u_chk (.clock(clock), .reset(reset),
  .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
  .regRead(regRead), .regReadData(regReadData),
  .serialClockIn(serialClockIn), .serialClockOut(serialClockOut),
  .serialClockOe(serialClockOe), .serialDataIn(serialDataIn),
  .serialDataOut(serialDataOut), .transferIrq(transferIrq));

/* scs_defs.vh */
// Register map, field positions and reset values of the clocked serial unit
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

// Register indices on the local register port
`define SCS_ADDR_W 3
`define SCS_IDX_CTRL 3'h0
`define SCS_IDX_CSR 3'h1
`define SCS_IDX_UPPER 3'h2
`define SCS_IDX_LOWER 3'h3
`define SCS_IDX_IRQ 3'h4

// Reset values
`define SCS_CTRL_RST 8'h00
`define SCS_CSR_RST 8'h80
`define SCS_DATA_RST 8'h00

// Serial control register fields
`define SCS_MODE_HI 7
`define SCS_MODE_LO 6
`define SCS_SRC_BIT 3
`define SCS_PRE_HI 2
`define SCS_PRE_LO 0

// Mode field codes
`define SCS_MODE_8 2'h0
`define SCS_MODE_16 2'h1
`define SCS_MODE_CONT 2'h2

// Control/status register fields
`define SCS_CSR_ONE 7
`define SCS_CSR_LEVEL 6
`define SCS_CSR_OVR 5
`define SCS_CSR_KEEP0 1
`define SCS_CSR_START 0

// Interrupt register fields
`define SCS_IRQ_FLAG 0
`define SCS_IRQ_EN 1

// Word lengths in bits
`define SCS_LEN_8 5'h08
`define SCS_LEN_16 5'h10

// Internal serial clock half periods in system clocks, by prescale code
`define SCS_HALF_0 10'h200
`define SCS_HALF_1 10'h080
`define SCS_HALF_2 10'h020
`define SCS_HALF_3 10'h010
`define SCS_HALF_4 10'h008
`define SCS_HALF_5 10'h004
`define SCS_HALF_6 10'h002
`define SCS_HALF_7 10'h001

`endif

/* scs_partner.sv */
// Far-side serial peripheral model
module scs_partner (
  // Line
  input wire lineClk,
  input wire dataOut,
  output logic dataIn,
  // Test control
  input wire load,
  input wire [15:0] txWord,
  output logic [15:0] rxWord,
  output logic [4:0] falls
);
  timeunit 1ns;
  timeprecision 1ns;
  // Next bit on each falling edge; idle shows inverse of first bit
  always @(negedge lineClk or posedge load) begin
    if (load) begin
      falls <= 5'h00;
      dataIn <= ~txWord[0];
    end else begin
      dataIn <= txWord[falls[3:0]];
      falls <= falls + 5'h01;
    end
  end
  // Capture on each rising edge
  always @(posedge lineClk) begin
    rxWord <= {dataOut, rxWord[15:1]};
  end
endmodule // scs_partner

/* scs_serial.v */
// Clocked serial unit: 8/16-bit LSB-first shifter with register port
//
// Functional notes
// - Level bit drives data pin, reads pin
// - Pin keeps last bit; level valid until start
// - External clock after completion sets overrun
// - Overrun clears by write 0 after read 1
// - Bits four to two read zero
// - Start flag starts, reads busy, clears done
// - Eight-bit: lower shifts out, input at MSB
// - Sixteen-bit: upper feeds lower, input enters upper
// - Sixteen-bit path equals eight-bit except input
// - Internal source drives clock pin, external inputs
// - Continuous mode with internal source drives prescaler clock always
// - Drive on falling edge, sample on rising
// - Control register write resets sequencer and divider
// - Completion sets request flag, gated by enable
// - Internal clock pulses only during transfer, except in continuous mode
// - Eight or sixteen bit words, either clock
// - Mode codes 00, 01, 10; 11 reserved
// - Control write during transfer stops it
// - Source bit: 0 prescaler output, 1 input
//
// The register addresses and the plain strobed port were chosen for this implementation.
`include "scs_defs.vh"

module scs_serial (
  // Clock and reset
  input wire clock,
  input wire reset,
  // Register port
  input wire [`SCS_ADDR_W-1:0] regAddr,
  input wire [7:0] regWriteData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regReadData,
  // Serial pins
  input wire serialClockIn,
  output reg serialClockOut,
  output reg serialClockOe,
  input wire serialDataIn,
  output reg serialDataOut,
  // Request to the interrupt controller
  output reg transferIrq
);

  // Half period of the internal serial clock in system clocks
  function [9:0] halfPeriod;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: halfPeriod = `SCS_HALF_0;
        3'h1: halfPeriod = `SCS_HALF_1;
        3'h2: halfPeriod = `SCS_HALF_2;
        3'h3: halfPeriod = `SCS_HALF_3;
        3'h4: halfPeriod = `SCS_HALF_4;
        3'h5: halfPeriod = `SCS_HALF_5;
        3'h6: halfPeriod = `SCS_HALF_6;
        default: halfPeriod = `SCS_HALF_7;
      endcase
    end
  endfunction

  // Word length for the mode field
  function [4:0] wordLen;
    input [1:0] mode;
    begin
      if (mode == `SCS_MODE_16) begin
        wordLen = `SCS_LEN_16;
      end else begin
        wordLen = `SCS_LEN_8;
      end
    end
  endfunction

  // Software-visible registers and flags, and the overrun read record
  reg [7:0] control_reg;
  reg [7:0] dataUpper_reg;
  reg [7:0] dataLower_reg;
  reg busy_reg;
  reg overrun_reg;
  reg overrunSeen_reg;
  reg keepZero_reg;
  reg irqFlag_reg;
  reg irqEnable_reg;
  // Sequencing and divider state
  reg [4:0] bitCount_reg;
  reg [9:0] divCount_reg;
  reg intClock_reg;
  // Pin synchronisers; only stage two and the clock edge history feed logic
  reg sckSync1_reg;
  reg sckSync2_reg;
  reg sckPrev_reg;
  reg sdiSync1_reg;
  reg sdiSync2_reg;

  // Control field views
  wire [1:0] mode = control_reg[`SCS_MODE_HI:`SCS_MODE_LO];
  wire extClock = control_reg[`SCS_SRC_BIT];
  wire [2:0] preSel = control_reg[`SCS_PRE_HI:`SCS_PRE_LO];
  wire wordMode = (mode == `SCS_MODE_8) || (mode == `SCS_MODE_16);
  wire contMode = (mode == `SCS_MODE_CONT);
  // Register port decodes
  wire wrCtrl = regWrite && (regAddr == `SCS_IDX_CTRL);
  wire wrCsr = regWrite && (regAddr == `SCS_IDX_CSR);
  wire wrUpper = regWrite && (regAddr == `SCS_IDX_UPPER);
  wire wrLower = regWrite && (regAddr == `SCS_IDX_LOWER);
  wire wrIrq = regWrite && (regAddr == `SCS_IDX_IRQ);
  wire rdCsr = regRead && (regAddr == `SCS_IDX_CSR);

  // Internal divider reaches half period
  wire divEnd = (divCount_reg == halfPeriod(preSel) - 10'h001);
  wire intRun = !extClock && (contMode || busy_reg);
  wire intFall = intRun && divEnd && intClock_reg;
  wire intRise = intRun && divEnd && !intClock_reg;
  // External clock edges, taken after the synchroniser
  wire extFall = extClock && sckPrev_reg && !sckSync2_reg;
  wire extRise = extClock && !sckPrev_reg && sckSync2_reg;
  // Shift strobes, only while a word transfer runs
  wire shiftFall = busy_reg && wordMode && (intFall || extFall);
  wire shiftRise = busy_reg && wordMode && (intRise || extRise);
  // Word end and accepted start request
  wire lastBit = (bitCount_reg == wordLen(mode) - 5'h01);
  wire finish = shiftRise && lastBit;
  wire startReq = wrCsr && regWriteData[`SCS_CSR_START] && wordMode;

  // Pin synchronisers and external edge history
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      sckSync1_reg <= 1'b1;
      sckSync2_reg <= 1'b1;
      sckPrev_reg <= 1'b1;
      sdiSync1_reg <= 1'b0;
      sdiSync2_reg <= 1'b0;
    end else begin
      sckSync1_reg <= serialClockIn;
      sckSync2_reg <= sckSync1_reg;
      sckPrev_reg <= sckSync2_reg;
      sdiSync1_reg <= serialDataIn;
      sdiSync2_reg <= sdiSync1_reg;
    end
  end

  // Serial control register
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      control_reg <= `SCS_CTRL_RST;
    end else if (wrCtrl) begin
      control_reg <= regWriteData;
    end
  end

  // Internal clock divider; idle level high
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      divCount_reg <= 10'h000;
      intClock_reg <= 1'b1;
    end else if (wrCtrl || startReq || !intRun) begin
      divCount_reg <= 10'h000;
      intClock_reg <= 1'b1;
    end else if (divEnd) begin
      divCount_reg <= 10'h000;
      intClock_reg <= !intClock_reg;
    end else begin
      divCount_reg <= divCount_reg + 10'h001;
    end
  end

  // Transfer sequencing and start flag
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      busy_reg <= 1'b0;
      bitCount_reg <= 5'h00;
    end else if (wrCtrl) begin
      busy_reg <= 1'b0;
      bitCount_reg <= 5'h00;
    end else if (startReq) begin
      busy_reg <= 1'b1;
      bitCount_reg <= 5'h00;
    end else if (finish) begin
      busy_reg <= 1'b0;
      bitCount_reg <= 5'h00;
    end else if (shiftRise) begin
      bitCount_reg <= bitCount_reg + 5'h01;
    end
  end

  // Data registers and shift path
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      dataUpper_reg <= `SCS_DATA_RST;
      dataLower_reg <= `SCS_DATA_RST;
    end else if (shiftRise) begin
      // Sample on rising edge, input enters the top
      if (mode == `SCS_MODE_16) begin
        dataUpper_reg <= {sdiSync2_reg, dataUpper_reg[7:1]};
        dataLower_reg <= {dataUpper_reg[0], dataLower_reg[7:1]};
      end else begin
        dataLower_reg <= {sdiSync2_reg, dataLower_reg[7:1]};
      end
    end else begin
      if (wrUpper) begin
        dataUpper_reg <= regWriteData;
      end
      if (wrLower) begin
        dataLower_reg <= regWriteData;
      end
    end
  end

  // Data pin level: forced by software, else last shifted bit
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      serialDataOut <= 1'b0;
    end else if (shiftFall) begin
      serialDataOut <= dataLower_reg[0];
    end else if (wrCsr && !busy_reg) begin
      serialDataOut <= regWriteData[`SCS_CSR_LEVEL];
    end
  end

  // Overrun flag and the read-as-one record
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      overrun_reg <= 1'b0;
      overrunSeen_reg <= 1'b0;
    end else begin
      if (extRise && !busy_reg && wordMode) begin
        overrun_reg <= 1'b1;
      end else if (wrCsr && overrunSeen_reg &&
                   !regWriteData[`SCS_CSR_OVR]) begin
        overrun_reg <= 1'b0;
      end
      if (wrCsr) begin
        overrunSeen_reg <= 1'b0;
      end else if (rdCsr && overrun_reg) begin
        overrunSeen_reg <= 1'b1;
      end
    end
  end

  // Spare bit one of control/status, stored as written
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      keepZero_reg <= 1'b0;
    end else if (wrCsr) begin
      keepZero_reg <= regWriteData[`SCS_CSR_KEEP0];
    end
  end

  // Completion request flag and its enable; set wins over clear
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      irqFlag_reg <= 1'b0;
      irqEnable_reg <= 1'b0;
    end else begin
      if (finish) begin
        irqFlag_reg <= 1'b1;
      end else if (wrIrq && !regWriteData[`SCS_IRQ_FLAG]) begin
        irqFlag_reg <= 1'b0;
      end
      if (wrIrq) begin
        irqEnable_reg <= regWriteData[`SCS_IRQ_EN];
      end
    end
  end

  // Pin drivers and interrupt output
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      serialClockOut <= 1'b1;
      serialClockOe <= 1'b0;
      transferIrq <= 1'b0;
    end else begin
      serialClockOut <= intClock_reg;
      serialClockOe <= !extClock;
      transferIrq <= irqFlag_reg && irqEnable_reg;
    end
  end

  // Read data, valid in the cycle after the strobe
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      regReadData <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        `SCS_IDX_CTRL: regReadData <= control_reg;
        `SCS_IDX_CSR: regReadData <= {1'b1, serialDataOut, overrun_reg,
                                      3'h0, keepZero_reg, busy_reg};
        `SCS_IDX_UPPER: regReadData <= dataUpper_reg;
        `SCS_IDX_LOWER: regReadData <= dataLower_reg;
        `SCS_IDX_IRQ: regReadData <= {6'h00, irqEnable_reg, irqFlag_reg};
        default: regReadData <= 8'h00;
      endcase
    end else begin
      regReadData <= 8'h00;
    end
  end

endmodule // scs_serial

/* test_scs_serial.sv */
// Testbench of the clocked serial unit
`include "scs_defs.vh"
module test_scs_serial;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [`SCS_ADDR_W-1:0] regAddr = 3'h0;
  logic [7:0] regWriteData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic extClk = 1'b1;
  logic load = 1'b0;
  logic [15:0] txWord = 16'h0000;
  logic [7:0] rd;
  wire [7:0] regReadData;
  wire serialClockOut, serialClockOe, serialDataIn, serialDataOut;
  wire transferIrq;
  wire [15:0] rxWord;
  wire [4:0] falls;
  wire lineClk = serialClockOe ? serialClockOut : extClk;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int divRatio[8] = '{1024, 256, 64, 32, 16, 8, 4, 2};
  time t0;
  scs_serial u_dut (.clock(clock), .reset(reset), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .serialClockIn(lineClk),
    .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
    .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
    .transferIrq(transferIrq));
  scs_partner u_far (.lineClk(lineClk), .dataOut(serialDataOut),
    .dataIn(serialDataIn), .load(load), .txWord(txWord), .rxWord(rxWord),
    .falls(falls));
  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rdr(input logic [2:0] a);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 rd = regReadData;
    @(posedge clock);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    rdr(a);
    chk({8'h00, rd}, {8'h00, e});
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      extClk <= 1'b0;
      repeat (8) @(posedge clock);
      extClk <= 1'b1;
      repeat (8) @(posedge clock);
    end
  endtask
  // One whole transfer with checks of data, pins and flags
  task automatic xfer(input logic [7:0] c, u, l, input logic [15:0] t);
    logic lvl;
    lvl = c[6] ? u[7] : l[7];
    wr(`SCS_IDX_CTRL, c);
    wr(`SCS_IDX_UPPER, u);
    wr(`SCS_IDX_LOWER, l);
    wr(`SCS_IDX_IRQ, 8'h02);
    txWord <= t;
    load <= 1'b1;
    @(posedge clock);
    load <= 1'b0;
    chk({15'h0000, serialClockOe}, {15'h0000, ~c[3]});
    wr(`SCS_IDX_CSR, 8'h01);
    rdr(`SCS_IDX_CSR);
    chk({15'h0000, rd[0]}, 16'h0001);
    if (c[3])
      pulses(c[6] ? 16 : 8);
    for (int i = 0; i < 100 && rd[0] !== 1'b0; i++)
      rdr(`SCS_IDX_CSR);
    chk({8'h00, rd}, {8'h00, 1'b1, lvl, 6'h00});
    chk({15'h0000, serialDataOut}, {15'h0000, lvl});
    chk({15'h0000, transferIrq}, 16'h0001);
    chk({11'h000, falls}, c[6] ? 16'h0010 : 16'h0008);
    rchk(`SCS_IDX_LOWER, t[7:0]);
    rchk(`SCS_IDX_UPPER, c[6] ? t[15:8] : u);
    chk(c[6] ? rxWord : {8'h00, rxWord[15:8]},
      c[6] ? {u, l} : {8'h00, l});
  endtask
  always #50 clock = ~clock;
  // Hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rchk(`SCS_IDX_CTRL, 8'h00);
    rchk(`SCS_IDX_CSR, 8'h80);
    rchk(`SCS_IDX_IRQ, 8'h00);
    rchk(3'h5, 8'h00);
    wr(`SCS_IDX_CSR, 8'h5C);
    rchk(`SCS_IDX_CSR, 8'hC0);
    chk({15'h0000, serialDataOut}, 16'h0001);
    xfer(8'h05, 8'h11, 8'hA5, 16'h003C);
    xfer(8'h45, 8'h12, 8'h34, 16'hBEEF);
    xfer(8'h48, 8'h9C, 8'hE1, 16'h5A0F);
    xfer(8'h08, 8'h77, 8'h5A, 16'h00C3);
    pulses(1);
    wr(`SCS_IDX_CSR, 8'h00);
    rchk(`SCS_IDX_CSR, 8'hA0);
    rchk(`SCS_IDX_LOWER, 8'hC3);
    wr(`SCS_IDX_CSR, 8'h20);
    wr(`SCS_IDX_CSR, 8'h00);
    rchk(`SCS_IDX_CSR, 8'hA0);
    wr(`SCS_IDX_CSR, 8'h00);
    rchk(`SCS_IDX_CSR, 8'h80);
    wr(`SCS_IDX_IRQ, 8'h02);
    wr(`SCS_IDX_CTRL, 8'h00);
    wr(`SCS_IDX_CSR, 8'h01);
    wr(`SCS_IDX_CTRL, 8'h00);
    rchk(`SCS_IDX_CSR, 8'h80);
    chk({15'h0000, transferIrq}, 16'h0000);
    // Continuous clock period for every prescale code
    for (int p = 0; p < 8; p++) begin
      wr(`SCS_IDX_CTRL, {5'h10, p[2:0]});
      @(negedge serialClockOut) t0 = $time;
      @(negedge serialClockOut);
      chk(16'(($time - t0) / 100), 16'(divRatio[p]));
    end
    for (int m = 2; m < 4; m++) begin
      wr(`SCS_IDX_CTRL, {m[1:0], 6'h07});
      wr(`SCS_IDX_CSR, 8'h01);
      rchk(`SCS_IDX_CSR, 8'h80);
    end
    end_sim();
  end
endmodule // test_scs_serial
